// [src/flash_seq_defines.svh]
// opcodes, address fields and timing counts of the flash sequencer
// assumes the includer runs on mclk at 100 MHz
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH
`define OP_WRITE_EN  8'h06
`define OP_SR_ERASE  8'h44
`define OP_SR_PROG   8'h42
`define OP_SR_READ   8'h48
`define OP_RST_EN    8'h66
`define OP_RST       8'h99
`define OP_PAUSE     8'h75
`define OP_CONT      8'h7A
`define OP_PP        8'h02
`define OP_QPP       8'h32
`define OP_SE        8'h20
`define OP_BE32      8'h52
`define OP_BE64      8'hD8
`define OP_CE_A      8'h60
`define OP_CE_B      8'hC7
// security register address fields
`define SR_HI_ZERO   8'h00
`define SR_SEL_HI    3'h0
`define SR_GAP       2'h0
`define SR_SEL_BIT   12
`define ERASED_BYTE  8'hFF
// timing
`define CLK_NS       10
`define RESUME_NS    200
`define RESUME_CYC   (`RESUME_NS / `CLK_NS)
`define SCK_HALF     8
`endif

// [src/flash_seq_pkg.sv]
// types shared by both ends of the serial flash link
// assumes nothing beyond a SystemVerilog compiler
package flash_seq_pkg;
  typedef enum logic [4:0] {
    JOB_NONE     = 5'b00001,
    JOB_SR_ERASE = 5'b00010,
    JOB_SR_PROG  = 5'b00100,
    JOB_ARR_PROG = 5'b01000,
    JOB_ARR_ERAS = 5'b10000
  } job_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW  = 4'b0010,
    H_HIGH = 4'b0100,
    H_GAP  = 4'b1000
  } host_state_t;
endpackage

// [src/flash_link_if.sv]
// serial link between the flash device end and the host end
// assumes the bench instantiates it and connects both modports
`timescale 1ns/100ps
`default_nettype none
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  // serial output floats high when the device does not drive it
  assign so_line = so_oe ? so : 1'b1;
  modport dev  (input cs_n, sclk, si, output so, so_oe);
  modport host (output cs_n, sclk, si, input so_line);
endinterface
`default_nettype wire

// [src/pin_sync.sv]
// two-flop synchroniser for asynchronous pins
// assumes d comes from outside the mclk domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
)(
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      meta <= INIT;
      q    <= INIT;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

// [src/flash_dev_end.sv]
// device end: security registers, software reset, suspend and resume
// assumes mclk far faster than sclk; lock bits come from mclk logic
// Functional notes
// - two independent 1024-byte security registers
// - host sets write enable before erase
// - erase 44H, three address bytes, exact end
// - register chosen by address bits 15-12
// - erase sets busy, clears write enable
// - locked register ignores erase
// - program 42H, address, data, write enabled
// - program sets busy, clears write enable
// - locked register ignores program
// - four pages, bits 9-0 byte address
// - read 48H, address, dummy, data on falls
// - read address wraps 3FFH to 000H
// - reset needs 66H frame then 99H frame
// - reset aborts work, clears volatile state
// - no commands during reset recovery
// - host checks busy and pause before reset
// - suspend only while array work runs
// - suspend sets pause, busy drops later
// - program suspend rejects writes and erases
// - erase suspend rejects status write, erases
// - resume only while suspended and idle
// - resume clears pause, busy back quickly
//
// Chosen here: the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_dev_end
  import flash_seq_pkg::*;
#(
  parameter int SR_BYTES   = 1024,
  parameter int PAGE_BYTES = 256,
  parameter int ERASE_CYC  = 64,
  parameter int PROG_CYC   = 32,
  parameter int ARR_CYC    = 96,
  parameter int PAUSE_CYC  = 8,
  parameter int RST_CYC    = 16
)(
  input  wire logic mclk,
  input  wire logic rst_b,
  flash_link_if.dev link,
  input  wire logic security_lock_bit0,
  input  wire logic security_lock_bit1,
  output logic      write_enable_latch,
  output logic      write_in_progress,
  output logic      pause_flag,
  output logic      soft_reset_pulse
);
  localparam int AW = $clog2(SR_BYTES);
  localparam int PW = $clog2(PAGE_BYTES);

  logic [2:0]    s_in;
  logic          cs_d;
  logic          sck_d;
  logic [7:0]    sh;
  logic [2:0]    bitn;
  logic [3:0]    nbytes;
  logic [7:0]    opcode;
  logic [23:0]   addr;
  logic [AW-1:0] raddr;
  logic          rsel;
  logic [2:0]    obit;
  logic [PW-1:0] pptr;
  logic [7:0]    mem [0:2*SR_BYTES-1];
  logic [7:0]    pbuf [0:PAGE_BYTES-1];
  job_t          job;
  job_t          sv_job;
  job_t          start_job;
  logic [15:0]   jcnt;
  logic [15:0]   sv_cnt;
  logic [15:0]   start_cyc;
  logic          jsel;
  logic [AW-PW-1:0] jpage;
  logic [15:0]   pcnt;
  logic [15:0]   rcnt;
  logic          armed;
  logic          jchip;

  function automatic logic sr_addr_ok(input logic [23:0] a);
    sr_addr_ok = (a[23:16] == `SR_HI_ZERO) && (a[15:13] == `SR_SEL_HI) && (a[11:10] == `SR_GAP);
  endfunction

  // ---------------------------------------------------------------
  // link sampling
  // ---------------------------------------------------------------
  pin_sync #(.W(3), .INIT(3'h4)) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     ({link.cs_n, link.sclk, link.si}),
    .q     (s_in)
  );

  logic       sel;
  logic       frame_start;
  logic       frame_end;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] byte_val;
  logic       byte_done;
  logic [23:0] addr_next;
  assign sel         = ~s_in[2];
  assign frame_start = ~s_in[2] & cs_d;
  assign frame_end   = s_in[2] & ~cs_d;
  assign sck_rise    = s_in[1] & ~sck_d;
  assign sck_fall    = ~s_in[1] & sck_d;
  assign byte_val    = {sh[6:0], s_in[0]};
  assign byte_done   = sck_rise & sel & (bitn == 3'h7);
  assign addr_next   = {addr[15:0], byte_val};

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      cs_d  <= s_in[2];
      sck_d <= s_in[1];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sh     <= 8'h00;
      bitn   <= 3'h0;
      nbytes <= 4'h0;
      opcode <= 8'h00;
      addr   <= 24'h000000;
    end
    else if (frame_start)
    begin
      bitn   <= 3'h0;
      nbytes <= 4'h0;
    end
    else if (sck_rise && sel)
    begin
      sh   <= byte_val;
      bitn <= bitn + 3'h1;
      if (bitn == 3'h7)
      begin
        if (nbytes != 4'hF)
          nbytes <= nbytes + 4'h1;
        if (nbytes == 4'h0)
          opcode <= byte_val;
        if (nbytes >= 4'h1 && nbytes <= 4'h3)
          addr <= addr_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  logic rd_phase;
  assign rd_phase = sel && (opcode == `OP_SR_READ) && (nbytes >= 4'h5) && (rcnt == 16'h0);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      link.so    <= 1'b1;
      link.so_oe <= 1'b0;
      obit       <= 3'h0;
      raddr      <= '0;
      rsel       <= 1'b0;
    end
    else
    begin
      link.so_oe <= rd_phase;
      if (frame_start)
        obit <= 3'h0;
      // low address bits index the register
      if (byte_done && nbytes == 4'h3)
      begin
        raddr <= addr_next[AW-1:0];
        rsel  <= addr_next[`SR_SEL_BIT];
      end
      // data shifted out on falling edges
      if (rd_phase && sck_fall)
      begin
        link.so <= mem[{rsel, raddr}][3'h7 - obit];
        obit    <= obit + 3'h1;
        if (obit == 3'h7)
          raddr <= raddr + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // program buffer and security register storage
  // ---------------------------------------------------------------
  logic job_done;
  assign job_done = (job != JOB_NONE) && (jcnt == 16'h1);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pptr <= '0;
      for (int i = 0; i < PAGE_BYTES; i++)
        pbuf[i] <= `ERASED_BYTE;
      for (int i = 0; i < 2*SR_BYTES; i++)
        mem[i] <= `ERASED_BYTE;
    end
    else
    begin
      // buffer frozen while its own program is still running
      if (job != JOB_SR_PROG)
      begin
        if (frame_start)
          for (int i = 0; i < PAGE_BYTES; i++)
            pbuf[i] <= `ERASED_BYTE;
        else if (byte_done && nbytes == 4'h3)
          pptr <= addr_next[PW-1:0];
        else if (byte_done && nbytes >= 4'h4 && opcode == `OP_SR_PROG)
        begin
          pbuf[pptr] <= byte_val;
          pptr       <= pptr + 1'b1;
        end
      end
      // each register erased or programmed on its own
      if (job_done && job == JOB_SR_ERASE)
        for (int i = 0; i < SR_BYTES; i++)
          mem[{jsel, AW'(i)}] <= `ERASED_BYTE;
      if (job_done && job == JOB_SR_PROG)
        for (int i = 0; i < PAGE_BYTES; i++)
          mem[{jsel, jpage, PW'(i)}] <= mem[{jsel, jpage, PW'(i)}] & pbuf[i];
    end
  end

  // ---------------------------------------------------------------
  // command decode at frame end
  // ---------------------------------------------------------------
  logic whole;
  logic n1;
  logic n4;
  logic ndata;
  logic sr_ok;
  logic may_write;
  logic prog_paused;
  assign whole       = (bitn == 3'h0);
  assign n1          = whole && (nbytes == 4'h1);
  assign n4          = whole && (nbytes == 4'h4);
  assign ndata       = whole && (nbytes >= 4'h5);
  assign sr_ok       = sr_addr_ok(addr) &&
                       !(addr[`SR_SEL_BIT] ? security_lock_bit1 : security_lock_bit0);
  // gate on recovery and write enable
  assign may_write   = frame_end && (rcnt == 16'h0) && write_enable_latch && !write_in_progress;
  assign prog_paused = pause_flag && (sv_job != JOB_ARR_ERAS);

  always_comb
  begin
    start_job = JOB_NONE;
    start_cyc = 16'h0;
    if (may_write)
    begin
      if (n4 && opcode == `OP_SR_ERASE && sr_ok && !pause_flag)
      begin
        start_job = JOB_SR_ERASE;
        start_cyc = 16'(ERASE_CYC);
      end
      // program needs data, no program suspend
      else if (ndata && opcode == `OP_SR_PROG && sr_ok && !prog_paused)
      begin
        start_job = JOB_SR_PROG;
        start_cyc = 16'(PROG_CYC);
      end
      else if (ndata && (opcode == `OP_PP || opcode == `OP_QPP) && !prog_paused)
      begin
        start_job = JOB_ARR_PROG;
        start_cyc = 16'(ARR_CYC);
      end
      else if (!pause_flag && ((n4 && (opcode == `OP_SE || opcode == `OP_BE32 ||
               opcode == `OP_BE64)) || (n1 && (opcode == `OP_CE_A || opcode == `OP_CE_B))))
      begin
        start_job = JOB_ARR_ERAS;
        start_cyc = 16'(ARR_CYC);
      end
    end
  end

  // ---------------------------------------------------------------
  // status and sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      job <= JOB_NONE;
      sv_job <= JOB_NONE;
      jcnt <= 16'h0;
      sv_cnt <= 16'h0;
      jsel <= 1'b0;
      jpage <= '0;
      pcnt <= 16'h0;
      rcnt <= 16'h0;
      armed <= 1'b0;
      jchip <= 1'b0;
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
      pause_flag <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      soft_reset_pulse <= 1'b0;
      if (rcnt != 16'h0)
        rcnt <= rcnt - 16'h1;
      // busy drops after the pause latency
      if (pcnt != 16'h0)
      begin
        pcnt <= pcnt - 16'h1;
        if (pcnt == 16'h1)
          write_in_progress <= 1'b0;
      end
      if (job_done)
      begin
        job <= JOB_NONE;
        write_in_progress <= 1'b0;
      end
      else if (job != JOB_NONE)
        jcnt <= jcnt - 16'h1;
      // busy on, write enable off at start
      if (start_job != JOB_NONE)
      begin
        job <= start_job;
        jcnt <= start_cyc;
        jsel <= addr[`SR_SEL_BIT];
        jpage <= addr[AW-1:PW];
        // only a chip erase starts from a one-byte frame
        jchip <= n1;
        write_in_progress <= 1'b1;
        write_enable_latch <= 1'b0;
      end
      if (frame_end && rcnt == 16'h0)
      begin
        // any other frame disarms the reset
        armed <= n1 && (opcode == `OP_RST_EN);
        if (n1 && opcode == `OP_RST && armed)
        begin
          job <= JOB_NONE;
          sv_job <= JOB_NONE;
          pcnt <= 16'h0;
          write_enable_latch <= 1'b0;
          write_in_progress <= 1'b0;
          pause_flag <= 1'b0;
          soft_reset_pulse <= 1'b1;
          rcnt <= 16'(RST_CYC);
        end
        else if (n1 && opcode == `OP_WRITE_EN)
          write_enable_latch <= 1'b1;
        // suspend only array work, not yet paused
        else if (n1 && opcode == `OP_PAUSE && write_in_progress && !pause_flag &&
                 !jchip && (job == JOB_ARR_PROG || job == JOB_ARR_ERAS))
        begin
          pause_flag <= 1'b1;
          sv_job <= job;
          sv_cnt <= jcnt;
          job <= JOB_NONE;
          pcnt <= 16'(PAUSE_CYC);
        end
        // resume restores job, busy at once
        else if (n1 && opcode == `OP_CONT && pause_flag && !write_in_progress)
        begin
          pause_flag <= 1'b0;
          job <= sv_job;
          jcnt <= sv_cnt;
          sv_job <= JOB_NONE;
          write_in_progress <= 1'b1;
        end
      end
    end
  end
endmodule // flash_dev_end
`default_nettype wire

// [src/flash_host_end.sv]
// host end: frames one command with address, dummy and data bytes
// assumes user software orders write enable and status checks
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defines.svh"
module flash_host_end
  import flash_seq_pkg::*;
#(
  parameter int SCK_HALF = `SCK_HALF,
  parameter int LEN_W    = 11
)(
  input  wire logic             mclk,
  input  wire logic             rst_b,
  flash_link_if.host            link,
  input  wire logic             start,
  input  wire logic [7:0]       opcode,
  input  wire logic [23:0]      addr,
  input  wire logic             addr_en,
  input  wire logic             dummy_en,
  input  wire logic [LEN_W-1:0] data_len,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_take,
  output logic [7:0]            rx_data,
  output logic                  rx_valid,
  output logic                  busy
);
  host_state_t st;
  logic [15:0] div;
  logic [7:0]  sh_out;
  logic [7:0]  sh_in;
  logic [2:0]  bitc;
  logic [LEN_W:0] left;
  logic [31:0] hdr;
  logic [2:0]  hdr_n;
  logic        s_so;
  logic        half_up;
  logic [7:0]  nxt;

  pin_sync #(.W(1), .INIT(1'b1)) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (link.so_line),
    .q     (s_so)
  );

  assign half_up = (div == 16'(SCK_HALF - 1));
  assign nxt     = (hdr_n != 3'h0) ? hdr[31:24] : tx_data;

  // ---------------------------------------------------------------
  // frame sequencer, clock divided from mclk
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st <= H_IDLE;
      div <= 16'h0;
      sh_out <= 8'h00;
      sh_in <= 8'h00;
      bitc <= 3'h0;
      left <= '0;
      hdr <= 32'h0;
      hdr_n <= 3'h0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.si <= 1'b0;
      tx_take <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      tx_take <= 1'b0;
      rx_valid <= 1'b0;
      div <= half_up ? 16'h0 : div + 16'h1;
      unique case (st)
        H_IDLE:
        begin
          div <= 16'h0;
          if (start)
          begin
            st <= H_LOW;
            busy <= 1'b1;
            link.cs_n <= 1'b0;
            link.si <= opcode[7];
            sh_out <= opcode;
            bitc <= 3'h0;
            hdr <= addr_en ? {addr, 8'h00} : 32'h0;
            hdr_n <= (addr_en ? 3'h3 : 3'h0) + (dummy_en ? 3'h1 : 3'h0);
            left <= (LEN_W+1)'(data_len) + (addr_en ? 3'h4 : 3'h1) + (dummy_en ? 1'b1 : 1'b0);
          end
        end
        H_LOW:
          // device samples on this rising edge
          if (half_up)
          begin
            st <= H_HIGH;
            link.sclk <= 1'b1;
            sh_in <= {sh_in[6:0], s_so};
          end
        H_HIGH:
          if (half_up)
          begin
            link.sclk <= 1'b0;
            bitc <= bitc + 3'h1;
            st <= H_LOW;
            if (bitc == 3'h7)
            begin
              left <= left - 1'b1;
              rx_data <= sh_in;
              rx_valid <= 1'b1;
              // select ends one half period after last byte
              if (left == 1)
                st <= H_GAP;
              else
              begin
                sh_out <= nxt;
                link.si <= nxt[7];
                if (hdr_n != 3'h0)
                begin
                  hdr <= {hdr[23:0], 8'h00};
                  hdr_n <= hdr_n - 3'h1;
                end
                else
                  tx_take <= 1'b1;
              end
            end
            else
            begin
              link.si <= sh_out[6];
              sh_out <= {sh_out[6:0], 1'b0};
            end
          end
        H_GAP:
          // one half period low, one high before the next frame
          if (half_up)
          begin
            if (!link.cs_n)
              link.cs_n <= 1'b1;
            else
            begin
              st <= H_IDLE;
              busy <= 1'b0;
            end
          end
      endcase
    end
  end
endmodule // flash_host_end
`default_nettype wire

// [bench/flash_seq_checker.sv]
// assertions on the flash link wires and the device status flags
// assumes one mclk domain; placed beside the link interface
`timescale 1ns/100ps
`default_nettype none
module flash_seq_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line,
  input wire logic write_enable_latch,
  input wire logic write_in_progress,
  input wire logic pause_flag,
  input wire logic soft_reset_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // link framing
  // ----------------------------------------
  // deselect long enough for the pin syncs to settle
  sequence s_quiet;
    cs_n [*8];
  endsequence
  sequence s_pause_drop;
    ##[0:12] !write_in_progress;
  endsequence
  sel_edge_a: assert property ($changed(cs_n) |-> !sclk)
    else $error("select moved while serial clock high");
  clk_framed_a: assert property ($changed(sclk) |-> !cs_n)
    else $error("serial clock moved outside a frame");
  si_hold_a: assert property (sclk && $past(sclk) |-> $stable(si))
    else $error("serial input changed while clock high");
  so_idle_a: assert property (s_quiet |-> !so_oe)
    else $error("serial output driven while deselected");
  so_line_a: assert property (so_line == (so | !so_oe))
    else $error("serial output line not as driven or not pulled high");
  // ----------------------------------------
  // status flags
  // ----------------------------------------
  job_start_a: assert property ($rose(write_in_progress) |-> cs_n && $past(cs_n, 3))
    else $error("busy rose without a closed frame");
  wel_drop_a: assert property ($rose(write_in_progress) && !$past(pause_flag)
    |-> !write_enable_latch)
    else $error("write enable still set at job start");
  pause_gate_a: assert property ($rose(pause_flag) |-> $past(write_in_progress))
    else $error("pause taken while idle");
  pause_lat_a: assert property ($rose(pause_flag) |-> s_pause_drop)
    else $error("busy did not drop after pause");
  resume_gate_a: assert property ($fell(pause_flag) && !soft_reset_pulse
    |-> !$past(write_in_progress))
    else $error("pause cleared while still busy");
  resume_busy_a: assert property ($fell(pause_flag) && !soft_reset_pulse
    && !$past(soft_reset_pulse) |-> ##[0:20] write_in_progress)
    else $error("busy not back after resume");
  rst_clear_a: assert property (soft_reset_pulse
    |-> ##[0:2] (!write_enable_latch && !pause_flag && !write_in_progress))
    else $error("state not cleared by soft reset");
  rst_frame_a: assert property (soft_reset_pulse |-> cs_n)
    else $error("soft reset inside a frame");
  recovery_a: assert property (soft_reset_pulse |-> ##3 (!write_in_progress) [*8])
    else $error("job started during reset recovery");
endmodule // flash_seq_checker
`default_nettype wire

// [bench/tb_flash_secreg_reset_suspend.sv]
// testbench: host end and device end joined by the link interface
// assumes mclk at 100 MHz; array job and recovery counts outlast one frame
`timescale 1ns/100ps
`default_nettype none
module tb_flash_secreg_reset_suspend;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic        addr_en = 1'b0;
  logic        dummy_en = 1'b0;
  logic [10:0] data_len = 11'h000;
  logic [7:0]  tx_data = 8'h00;
  logic        lk0 = 1'b0;
  logic        lk1 = 1'b0;
  logic        tx_take, rx_valid, busy;
  logic [7:0]  rx_data;
  logic        write_enable_latch, write_in_progress, pause_flag, soft_reset_pulse;
  logic [7:0]  txq[$];
  logic [7:0]  rxq[$];
  int          tx_idx = 0;
  int          npulse = 0;
  int          checked = 0;
  int          miscompares = 0;

  always #5 mclk = ~mclk;

  flash_link_if flash_link_if_inst ();
  flash_dev_end #(.ARR_CYC(400), .RST_CYC(300)) flash_dev_end_inst (.mclk(mclk),
    .rst_b(rst_b), .link(flash_link_if_inst.dev),
    .security_lock_bit0(lk0), .security_lock_bit1(lk1),
    .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
    .pause_flag(pause_flag), .soft_reset_pulse(soft_reset_pulse));
  flash_host_end flash_host_end_inst (.mclk(mclk), .rst_b(rst_b),
    .link(flash_link_if_inst.host), .start(start), .opcode(opcode), .addr(addr),
    .addr_en(addr_en), .dummy_en(dummy_en), .data_len(data_len), .tx_data(tx_data),
    .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));
  flash_seq_checker flash_seq_checker_inst (.mclk(mclk), .rst_b(rst_b),
    .cs_n(flash_link_if_inst.cs_n), .sclk(flash_link_if_inst.sclk),
    .si(flash_link_if_inst.si), .so(flash_link_if_inst.so),
    .so_oe(flash_link_if_inst.so_oe), .so_line(flash_link_if_inst.so_line),
    .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
    .pause_flag(pause_flag), .soft_reset_pulse(soft_reset_pulse));

  // ----------------------------------------
  // byte feed and capture
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (tx_take === 1'b1 && tx_idx < txq.size())
    begin
      tx_data <= txq[tx_idx];
      tx_idx <= tx_idx + 1;
    end
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
    if (soft_reset_pulse === 1'b1)
      npulse++;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // flags in the order write enable, busy, pause
  task automatic stat(input logic [2:0] e);
    chk("status", {5'h00, e}, {5'h00, write_enable_latch, write_in_progress, pause_flag});
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic ae,
                     input logic de, input int n);
    int i;
    i = 0;
    rxq.delete();
    @(posedge mclk);
    tx_idx <= 1;
    tx_data <= (txq.size() > 0) ? txq[0] : 8'h00;
    opcode <= op;
    addr <= a;
    addr_en <= ae;
    dummy_en <= de;
    data_len <= n[10:0];
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    while (busy !== 1'b0 && i < 4000)
    begin
      @(negedge mclk);
      i++;
    end
    if (i == 4000)
      chk("frame end", 8'h00, 8'h01);
  endtask

  task automatic write_enable;
    cmd(8'h06, 24'h000000, 1'b0, 1'b0, 0);
  endtask

  task automatic rd(input logic [23:0] a, input int n);
    cmd(8'h48, a, 1'b1, 1'b1, n);
  endtask

  // wait out a running job, bounded
  task automatic settle;
    int i;
    i = 0;
    while (write_in_progress !== 1'b0 && i < 1000)
    begin
      @(negedge mclk);
      i++;
    end
    if (i == 1000)
      chk("job end", 8'h00, 8'h01);
  endtask

  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    stat(3'b000);
    txq = '{8'hA5};
    cmd(8'h42, 24'h001000, 1'b1, 1'b0, 1);
    stat(3'b000);
    $display("test no_enable done");
    write_enable();
    stat(3'b100);
    txq = '{8'hA5, 8'h5A, 8'h3C};
    cmd(8'h42, 24'h0003FE, 1'b1, 1'b0, 3);
    stat(3'b010);
    settle();
    rd(24'h0003FE, 3);
    chk("rd3FE", 8'hA5, rxq[5]);
    chk("rd3FF", 8'h5A, rxq[6]);
    chk("rd000", 8'hFF, rxq[7]);
    rd(24'h000300, 1);
    chk("rd300", 8'h3C, rxq[5]);
    rd(24'h0013FF, 2);
    chk("sr1 3FF", 8'hFF, rxq[5]);
    chk("sr1 000", 8'hFF, rxq[6]);
    $display("test program done");
    write_enable();
    txq = '{8'h00};
    cmd(8'h44, 24'h000000, 1'b1, 1'b0, 1);
    stat(3'b100);
    cmd(8'h44, 24'h000400, 1'b1, 1'b0, 0);
    stat(3'b100);
    @(posedge mclk);
    lk0 <= 1'b1;
    cmd(8'h44, 24'h000000, 1'b1, 1'b0, 0);
    stat(3'b100);
    cmd(8'h42, 24'h000000, 1'b1, 1'b0, 1);
    stat(3'b100);
    @(posedge mclk);
    lk0 <= 1'b0;
    cmd(8'h44, 24'h000000, 1'b1, 1'b0, 0);
    stat(3'b010);
    settle();
    rd(24'h0003FE, 1);
    chk("erased", 8'hFF, rxq[5]);
    $display("test erase done");
    write_enable();
    txq = '{8'h11};
    cmd(8'h02, 24'h000100, 1'b1, 1'b0, 1);
    stat(3'b010);
    cmd(8'h75, 24'h000000, 1'b0, 1'b0, 0);
    settle();
    stat(3'b001);
    write_enable();
    txq = '{8'h22};
    cmd(8'h42, 24'h000010, 1'b1, 1'b0, 1);
    stat(3'b101);
    cmd(8'h7A, 24'h000000, 1'b0, 1'b0, 0);
    stat(3'b110);
    settle();
    rd(24'h000010, 1);
    chk("untouched", 8'hFF, rxq[5]);
    cmd(8'h75, 24'h000000, 1'b0, 1'b0, 0);
    stat(3'b100);
    cmd(8'h7A, 24'h000000, 1'b0, 1'b0, 0);
    stat(3'b100);
    $display("test program suspend done");
    cmd(8'h20, 24'h002000, 1'b1, 1'b0, 0);
    stat(3'b010);
    cmd(8'h75, 24'h000000, 1'b0, 1'b0, 0);
    settle();
    write_enable();
    cmd(8'h44, 24'h001000, 1'b1, 1'b0, 0);
    stat(3'b101);
    cmd(8'h99, 24'h000000, 1'b0, 1'b0, 0);
    stat(3'b101);
    cmd(8'h66, 24'h000000, 1'b0, 1'b0, 0);
    cmd(8'h99, 24'h000000, 1'b0, 1'b0, 0);
    stat(3'b000);
    chk("pulses", 8'h01, npulse[7:0]);
    write_enable();
    stat(3'b000);
    $display("test erase suspend and reset done");
    stop_test();
  end

  initial
  begin
    #600000;
    miscompares++;
    stop_test();
  end
endmodule // tb_flash_secreg_reset_suspend
`default_nettype wire
